// [hw/global_test_dither_control.sv]
// Global test control register with pin override, sine routing and dither
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Bit 16 drives pins from bits 31:21, the serial clock pin only on a divided clock
// - Bits 31..21 map to interrupt, sync, clock, data
// - Bit 15 opens data RAM test access
// - Bits 7:4 route sine MSB to second pin
// - Dither from 23-bit and/or 15-bit sequence
// - Bit 2 and bit 1 enable generators
// - Generator outputs XORed, each independently disabled
// - Bit 3 XORs I dither with bit 10 of the 23-bit generator state
// - Bit 0 enters internal self-test mode
module global_test_dither_control
	import test_dither_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RST_B,
	input  wire logic        WRITE_STROBE,
	input  wire logic [15:0] GLOBAL_WRITE_ADDRESS,
	input  wire logic [31:0] WRITE_DATA,
	input  wire logic        INTERRUPT_IN,
	input  wire logic        SYNC_OUT_IN,
	input  wire logic        SERIAL_CLOCK_IN,
	input  wire logic        SERIAL_CLOCK_DIVIDED,
	input  wire logic [3:0]  CHANNEL_SYNC_IN,
	input  wire logic [3:0]  FIRST_SERIAL_DATA_IN,
	input  wire logic [3:0]  SECOND_SERIAL_DATA_IN,
	input  wire logic [3:0]  OSCILLATOR_SINE_OUTPUT_MSB,
	output logic             INTERRUPT_PIN,
	output logic             SYNC_OUT_PIN,
	output logic             SERIAL_CLOCK_PIN,
	output logic             CHANNEL_A_SYNC_PIN,
	output logic             CHANNEL_B_SYNC_PIN,
	output logic             CHANNEL_C_SYNC_PIN,
	output logic             CHANNEL_D_SYNC_PIN,
	output logic             FIRST_SERIAL_DATA_A,
	output logic             FIRST_SERIAL_DATA_B,
	output logic             FIRST_SERIAL_DATA_C,
	output logic             FIRST_SERIAL_DATA_D,
	output logic [3:0]       SECOND_SERIAL_DATA,
	output logic             DATA_RAM_TEST_ENABLE,
	output logic             SELF_TEST_MODE,
	output logic             DITHER_I,
	output logic             DITHER_Q
);

	typedef struct packed {
		logic [31:0] ctrl;
		logic        intr;
		logic        sync_out;
		logic        serial_clock_pin;
		logic [3:0]  chan_sync;
		logic [3:0]  first_sd;
		logic [3:0]  second_sd;
		logic        dith_i;
		logic        dith_q;
	} ctl_s;

	ctl_s                  state_reg;
	ctl_s                  state_next;
	logic [PN23_WIDTH-1:0] pn23_state;
	logic [PN15_WIDTH-1:0] pn15_state;
	logic                  pn23_bit;
	logic                  pn15_bit;
	logic                  pn_comb;

	// Decoded control fields
	logic                  ctrl_write;
	logic                  ovr_en;
	logic                  serial_clock_pin_ovr_en;
	logic                  ovr_intr;
	logic                  ovr_sync_out;
	logic                  ovr_serial_clock_pin;
	logic [3:0]            ovr_chan_sync;
	logic [3:0]            ovr_first_sd;
	logic [3:0]            sine_sel;
	logic                  pn23_en;
	logic                  pn15_en;
	logic                  i_offset_en;
	logic                  i_offset_bit;

	// ==========================================
	// Control word fields
	// Accepted write: strobe at the control word address only
	assign ctrl_write = WRITE_STROBE && (GLOBAL_WRITE_ADDRESS == TEST_CONTROL_ADDR);

	// Override fields, all taken from the stored word
	assign ovr_en        = state_reg.ctrl[PIN_OVERRIDE_BIT];
	assign ovr_intr      = state_reg.ctrl[PIN_INTR_BIT];
	assign ovr_sync_out  = state_reg.ctrl[PIN_SYNC_OUT_BIT];
	assign ovr_serial_clock_pin    = state_reg.ctrl[PIN_SERIAL_CLOCK_PIN_BIT];
	assign ovr_chan_sync = state_reg.ctrl[PIN_CHAN_SYNC_HI:PIN_CHAN_SYNC_LO];
	assign ovr_first_sd  = state_reg.ctrl[PIN_FIRST_SD_HI:PIN_FIRST_SD_LO];

	// Serial clock pin obeys override only on a divided clock
	assign serial_clock_pin_ovr_en = ovr_en & SERIAL_CLOCK_DIVIDED;

	// Sine routing select, highest bit is channel 0
	for (genvar ch = 0; ch < 4; ch++) begin : g_sine_sel
		assign sine_sel[ch] = state_reg.ctrl[SINE_ROUTE_HI - ch];
	end

	// Dither controls, offset bit gated by bit 3 only
	assign pn23_en      = state_reg.ctrl[PN23_ENABLE_BIT];
	assign pn15_en      = state_reg.ctrl[PN15_ENABLE_BIT];
	assign i_offset_en  = state_reg.ctrl[I_OFFSET_BIT];
	assign i_offset_bit = i_offset_en & pn23_state[PN23_I_TAP];

	// ==========================================
	// Pseudo-noise generators
	pn_sequence_gen #(
		.WIDTH (PN23_WIDTH),
		.TAP   (PN23_TAP),
		.SEED  (PN23_SEED)
	) u_pn23 (
		.SYS_CLK (SYS_CLK),
		.RST_B   (RST_B),
		.ENABLE  (state_reg.ctrl[PN23_ENABLE_BIT]),
		.STATE   (pn23_state)
	);

	pn_sequence_gen #(
		.WIDTH (PN15_WIDTH),
		.TAP   (PN15_TAP),
		.SEED  (PN15_SEED)
	) u_pn15 (
		.SYS_CLK (SYS_CLK),
		.RST_B   (RST_B),
		.ENABLE  (state_reg.ctrl[PN15_ENABLE_BIT]),
		.STATE   (pn15_state)
	);

	// Disabled generators contribute zero, outputs XORed
	assign pn23_bit = pn23_en & pn23_state[PN23_WIDTH-1];
	assign pn15_bit = pn15_en & pn15_state[PN15_WIDTH-1];
	assign pn_comb  = pn23_bit ^ pn15_bit;

	// ==========================================
	// Next state: register write, pin muxes, dither
	always_comb begin
		state_next = state_reg;
		// Write-only control word, unused bits stored as written
		if (ctrl_write) begin
			state_next.ctrl = WRITE_DATA;
		end
		// Override pins from the stored word or pass normal sources
		if (ovr_en) begin
			state_next.intr      = ovr_intr;
			state_next.sync_out  = ovr_sync_out;
			state_next.chan_sync = ovr_chan_sync;
			state_next.first_sd  = ovr_first_sd;
		end else begin
			state_next.intr      = INTERRUPT_IN;
			state_next.sync_out  = SYNC_OUT_IN;
			state_next.chan_sync = CHANNEL_SYNC_IN;
			state_next.first_sd  = FIRST_SERIAL_DATA_IN;
		end
		// Serial clock follows override only with divided clock
		if (serial_clock_pin_ovr_en) begin
			state_next.serial_clock_pin = ovr_serial_clock_pin;
		end else begin
			state_next.serial_clock_pin = SERIAL_CLOCK_IN;
		end
		// Sine MSB replaces second serial output per channel
		for (int ch = 0; ch < 4; ch++) begin
			if (sine_sel[ch]) begin
				state_next.second_sd[ch] = OSCILLATOR_SINE_OUTPUT_MSB[ch];
			end else begin
				state_next.second_sd[ch] = SECOND_SERIAL_DATA_IN[ch];
			end
		end
		// Dither for Q, and I with optional decorrelation
		state_next.dith_q = pn_comb;
		state_next.dith_i = pn_comb ^ i_offset_bit;
	end

	// ==========================================
	// State register
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg.ctrl      <= TEST_CONTROL_RESET;
			state_reg.intr      <= 1'b0;
			state_reg.sync_out  <= 1'b0;
			state_reg.serial_clock_pin    <= 1'b0;
			state_reg.chan_sync <= 4'h0;
			state_reg.first_sd  <= 4'h0;
			state_reg.second_sd <= 4'h0;
			state_reg.dith_i    <= 1'b0;
			state_reg.dith_q    <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// Outputs
	// Shared pins, registered in both modes
	assign INTERRUPT_PIN        = state_reg.intr;
	assign SYNC_OUT_PIN         = state_reg.sync_out;
	assign SERIAL_CLOCK_PIN     = state_reg.serial_clock_pin;

	// Per-channel sync pins, A on the highest bit
	assign CHANNEL_A_SYNC_PIN   = state_reg.chan_sync[3];
	assign CHANNEL_B_SYNC_PIN   = state_reg.chan_sync[2];
	assign CHANNEL_C_SYNC_PIN   = state_reg.chan_sync[1];
	assign CHANNEL_D_SYNC_PIN   = state_reg.chan_sync[0];

	// First and second serial data pins
	assign FIRST_SERIAL_DATA_A  = state_reg.first_sd[3];
	assign FIRST_SERIAL_DATA_B  = state_reg.first_sd[2];
	assign FIRST_SERIAL_DATA_C  = state_reg.first_sd[1];
	assign FIRST_SERIAL_DATA_D  = state_reg.first_sd[0];
	assign SECOND_SERIAL_DATA   = state_reg.second_sd;

	// Test modes straight from the stored word, dither from its own registers
	assign DATA_RAM_TEST_ENABLE = state_reg.ctrl[RAM_TEST_BIT];
	assign SELF_TEST_MODE       = state_reg.ctrl[SELF_TEST_BIT];
	assign DITHER_I             = state_reg.dith_i;
	assign DITHER_Q             = state_reg.dith_q;

endmodule

`default_nettype wire

// [hw/test_dither_pkg.sv]
// Constants for the global test and dither control block
package test_dither_pkg;

	// ==========================================
	// Register address and reset value
	localparam logic [15:0] TEST_CONTROL_ADDR  = 16'hf800;
	localparam logic [31:0] TEST_CONTROL_RESET = 32'h0000_0000;

	// ==========================================
	// Field positions in the test control word
	localparam int PIN_INTR_BIT       = 31;
	localparam int PIN_SYNC_OUT_BIT   = 30;
	localparam int PIN_SERIAL_CLOCK_PIN_BIT     = 29;
	localparam int PIN_CHAN_SYNC_HI   = 28;
	localparam int PIN_CHAN_SYNC_LO   = 25;
	localparam int PIN_FIRST_SD_HI    = 24;
	localparam int PIN_FIRST_SD_LO    = 21;
	localparam int PIN_OVERRIDE_BIT   = 16;
	localparam int RAM_TEST_BIT       = 15;
	localparam int SINE_ROUTE_HI      = 7;
	localparam int I_OFFSET_BIT       = 3;
	localparam int PN23_ENABLE_BIT    = 2;
	localparam int PN15_ENABLE_BIT    = 1;
	localparam int SELF_TEST_BIT      = 0;

	// ==========================================
	// Pseudo-noise generator shapes
	localparam int PN23_WIDTH = 23;
	localparam int PN23_TAP   = 18;
	localparam int PN15_WIDTH = 15;
	localparam int PN15_TAP   = 14;
	localparam int PN23_I_TAP = 10;
	localparam logic [22:0] PN23_SEED = 23'h000001;
	localparam logic [14:0] PN15_SEED = 15'h0001;

endpackage

// [hw/pn_sequence_gen.sv]
// Fibonacci maximal-length shift register for dither noise
`timescale 1ns/1ps
`default_nettype none

module pn_sequence_gen #(
	parameter int               WIDTH = 15,
	parameter int               TAP   = 14,
	parameter logic [WIDTH-1:0] SEED  = '1
) (
	input  wire logic             SYS_CLK,
	input  wire logic             RST_B,
	input  wire logic             ENABLE,
	output logic [WIDTH-1:0]      STATE
);

	typedef struct packed {
		logic [WIDTH-1:0] sr;
	} pn_s;

	pn_s state_reg;
	pn_s state_next;

	// ==========================================
	// One step per clock while enabled, hold otherwise
	always_comb begin
		state_next = state_reg;
		if (ENABLE) begin
			state_next.sr = {state_reg.sr[WIDTH-2:0], state_reg.sr[WIDTH-1] ^ state_reg.sr[TAP-1]};
		end
	end

	// State register
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg.sr <= SEED;
		end else begin
			state_reg <= state_next;
		end
	end

	assign STATE = state_reg.sr;

endmodule

`default_nettype wire

// [sim/global_test_dither_control_props.sv]
// Assertions on the ports of the global test and dither control block
`timescale 1ns/1ps
`default_nettype none
module global_test_dither_control_props
	import test_dither_pkg::*;
(
	input wire logic        SYS_CLK,
	input wire logic        RST_B,
	input wire logic        WRITE_STROBE,
	input wire logic [15:0] GLOBAL_WRITE_ADDRESS,
	input wire logic [31:0] WRITE_DATA,
	input wire logic        INTERRUPT_IN,
	input wire logic        INTERRUPT_PIN,
	input wire logic        SYNC_OUT_PIN,
	input wire logic        DATA_RAM_TEST_ENABLE,
	input wire logic        SELF_TEST_MODE,
	input wire logic        DITHER_I,
	input wire logic        DITHER_Q
);
	// ==========================================
	// Accepted write to the control word
	logic w;
	assign w = WRITE_STROBE && GLOBAL_WRITE_ADDRESS == TEST_CONTROL_ADDR;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	// ==========================================
	// Checks
	a_ram_test_bit: assert property (w |=> DATA_RAM_TEST_ENABLE == $past(WRITE_DATA[15]))
		else $error("ram test enable wrong");
	a_self_test_bit: assert property (w |=> SELF_TEST_MODE == $past(WRITE_DATA[0]))
		else $error("self test mode wrong");
	a_override_intr: assert property (w && WRITE_DATA[16] |-> ##2 INTERRUPT_PIN == $past(WRITE_DATA[31], 2))
		else $error("interrupt override wrong");
	a_override_sync: assert property (w && WRITE_DATA[16] |-> ##2 SYNC_OUT_PIN == $past(WRITE_DATA[30], 2))
		else $error("sync out override wrong");
	a_pin_normal: assert property (w && !WRITE_DATA[16] |-> ##2 INTERRUPT_PIN == $past(INTERRUPT_IN))
		else $error("interrupt pin not following source");
	a_dither_off: assert property (w && WRITE_DATA[3:1] == 3'b000 ##1 !w [*2] |=> !DITHER_Q && !DITHER_I)
		else $error("dither active while disabled");
	a_dither_same: assert property (w && !WRITE_DATA[3] ##1 !w [*2] |=> DITHER_I == DITHER_Q)
		else $error("dither paths differ");
	a_dither_runs: assert property (w && WRITE_DATA[2:1] == 2'b01 ##1 !w [*2] |-> ##[1:20] DITHER_Q)
		else $error("short generator stuck");
	cover property (w && WRITE_DATA[16]);
	cover property (w && WRITE_DATA[3:1] == 3'b111);
	cover property (DITHER_I != DITHER_Q);
endmodule
`default_nettype wire

// [sim/tb_global_test_dither_control.sv]
// Testbench for the global test and dither control block
`timescale 1ns/1ps
`default_nettype none
module tb_global_test_dither_control;
	logic        SYS_CLK = 0, RST_B = 0, WRITE_STROBE = 0, SERIAL_CLOCK_DIVIDED = 1;
	logic [15:0] GLOBAL_WRITE_ADDRESS = 0;
	logic [31:0] WRITE_DATA = 0;
	logic [10:0] src = 0;
	logic [3:0]  SECOND_SERIAL_DATA_IN = 4'ha, OSCILLATOR_SINE_OUTPUT_MSB = 4'h5, SECOND_SERIAL_DATA;
	wire logic   INTERRUPT_IN = src[10], SYNC_OUT_IN = src[9], SERIAL_CLOCK_IN = src[8];
	wire logic [3:0] CHANNEL_SYNC_IN = src[7:4], FIRST_SERIAL_DATA_IN = src[3:0];
	logic        INTERRUPT_PIN, SYNC_OUT_PIN, SERIAL_CLOCK_PIN, DATA_RAM_TEST_ENABLE, SELF_TEST_MODE;
	logic        CHANNEL_A_SYNC_PIN, CHANNEL_B_SYNC_PIN, CHANNEL_C_SYNC_PIN, CHANNEL_D_SYNC_PIN;
	logic        FIRST_SERIAL_DATA_A, FIRST_SERIAL_DATA_B, FIRST_SERIAL_DATA_C, FIRST_SERIAL_DATA_D;
	logic        DITHER_I, DITHER_Q, q;
	wire logic [10:0] pins = {INTERRUPT_PIN, SYNC_OUT_PIN, SERIAL_CLOCK_PIN, CHANNEL_A_SYNC_PIN,
		CHANNEL_B_SYNC_PIN, CHANNEL_C_SYNC_PIN, CHANNEL_D_SYNC_PIN, FIRST_SERIAL_DATA_A,
		FIRST_SERIAL_DATA_B, FIRST_SERIAL_DATA_C, FIRST_SERIAL_DATA_D};
	logic [3:0]  dv [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'he};
	logic [1:0]  ex [5] = '{2'b00, 2'b10, 2'b10, 2'b10, 2'b11};
	int          fail_count = 0, tests_run = 0, t, ne;

	global_test_dither_control u_dut (.*);

	// Clock
	always #20 SYS_CLK = ~SYS_CLK;

	// ==========================================
	// Tasks
	task tick(int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask

	task wr(logic [15:0] a, logic [31:0] d);
		{WRITE_STROBE, GLOBAL_WRITE_ADDRESS, WRITE_DATA} = {1'b1, a, d};
		tick(1);
		WRITE_STROBE = 0;
	endtask

	task chk(string n, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (5) @(posedge SYS_CLK);
		#1 RST_B = 1;
		src = 11'h5a3;
		tick(1);
		chk("pins", 32'h5a3, 32'(pins));
		wr(16'hf800, 32'h56a1_0000);
		tick(1);
		chk("pins", 32'h2b5, 32'(pins));
		wr(16'hf801, 32'h0);
		tick(1);
		chk("pins", 32'h2b5, 32'(pins));
		SERIAL_CLOCK_DIVIDED = 0;
		tick(2);
		chk("pins", 32'h3b5, 32'(pins));
		wr(16'hf800, 32'h0000_8001);
		chk("ram self", 32'h3, {30'h0, DATA_RAM_TEST_ENABLE, SELF_TEST_MODE});
		tick(1);
		chk("pins", 32'h5a3, 32'(pins));
		wr(16'hf800, 32'h0);
		chk("ram self", 32'h0, {30'h0, DATA_RAM_TEST_ENABLE, SELF_TEST_MODE});
		tick(1);
		for (int c = 0; c < 4; c++) begin
			wr(16'hf800, 32'h80 >> c);
			tick(1);
			chk("second", {28'h0, 4'ha ^ (4'h1 << c)}, {28'h0, SECOND_SERIAL_DATA});
		end
		for (int k = 0; k < 5; k++) begin
			wr(16'hf800, {28'h0, dv[k]});
			tick(3);
			t = 0;
			ne = 0;
			repeat (64) begin
				q = DITHER_Q;
				tick(1);
				t += int'(q !== DITHER_Q);
				ne += int'(DITHER_I !== DITHER_Q);
			end
			chk("dither", {30'h0, ex[k]}, {30'h0, t != 0, ne != 0});
			if (k == 0) begin
				chk("dither idle", 32'h0, {30'h0, DITHER_I, DITHER_Q});
			end
		end
		results();
	end

	// Hang guard
	initial begin
		#200000;
		fail_count++;
		results();
	end
endmodule

bind global_test_dither_control global_test_dither_control_props u_props (.*);
`default_nettype wire
